// ==== design/pos_paper_ctrl.sv ====
// Paper-out handling, self-test start and power-up switch configuration
// Operation
// R1: Paper end stops printing, drives status lines
// R2: Paper out forces off-line; line feed works
// R3: Online key after reload clears paper out
// R4: Power cycle or init clears all settings
// R5: Sensor-disable switch at power-up ignores sensor
// R6: Ignore command stops acting on sensor
// R7: Enable command resumes sensor, overriding switch
// R8: Line-feed key at power-up starts self-test
// R9: No self-test while out of paper
// R10: Spacing switch picks sixth or eighth inch
// R11: Form switch picks eleven or twelve inches
// R12: Size switches decode pitch and columns
// R13: Enlarged mode halves the column count
// R14: Charset switch plus bank two selects set
// R15: Select-force switch holds select-in asserted
// R16: Top-of-form resets at power-up and init
// R17: Online key ignored while printing
// R18: Paper-out lamp follows paper-end sensor
// R19: Switches sampled only at power-up or init
// R20: Paper-out held until release or disable
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pos_paper_ctrl
   import pos_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Paper sensor and panel
   input  wire logic        paper_end,
   input  wire logic        online_key,
   input  wire logic        line_feed_key,
   input  wire logic        printing,
   input  wire logic        enlarged,
   // Option switches
   input  wire logic        spacing_switch,
   input  wire logic        form_length_switch,
   input  wire logic        size_select_a,
   input  wire logic        size_select_b,
   input  wire logic        sensor_disable_switch,
   input  wire logic        charset_switch,
   input  wire logic [1:0]  charset_bank2,
   input  wire logic        select_force_switch,
   // Host interface
   input  wire logic        init_n,
   input  wire logic        sensor_ignore_command,
   input  wire logic        sensor_enable_command,
   input  wire logic        ack_request,
   output logic             error_n,
   output logic             paper_empty,
   output logic             busy,
   output logic             ack_n,
   output logic             select_in_force,
   // Printer core
   output logic             print_enable,
   output logic             feed_pulse,
   output logic             tof_reset,
   output logic             selftest_start,
   output logic             paper_out_lamp,
   output logic             online_lamp,
   output logic             spacing_eighth,
   output logic             form_twelve,
   output logic [1:0]       char_size,
   output logic [7:0]       max_columns,
   output logic [2:0]       charset_sel
);
   // ----------------------------------------------------------------
   // Key filtering
   // ----------------------------------------------------------------
   logic online_rise;
   logic lf_level;
   pos_sync_edge u_online (
      .pclk    (pclk),
      .presetn (presetn),
      .key_in  (online_key),
      .level   (),
      .rise    (online_rise)
   );
   pos_sync_edge u_lf (
      .pclk    (pclk),
      .presetn (presetn),
      .key_in  (line_feed_key),
      .level   (lf_level),
      .rise    ()
   );
   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   logic        wr_en;
   logic        sel_ctrl;
   logic        sel_status;
   logic        sel_config;
   logic        ctrl_wr;
   logic        sw_ignore;
   logic        sw_enable;
   logic        sw_init;
   assign pready     = 1'b1;
   assign sel_ctrl   = (paddr == POS_CTRL_OFF);
   assign sel_status = (paddr == POS_STATUS_OFF);
   assign sel_config = (paddr == POS_CONFIG_OFF);
   assign pslverr    = psel & penable & ~(sel_ctrl | sel_status | sel_config);
   assign wr_en      = psel & penable & pwrite;
   assign ctrl_wr    = wr_en & sel_ctrl & pstrb[0];
   assign sw_ignore  = ctrl_wr & pwdata[POS_CTRL_IGNORE_BIT];
   assign sw_enable  = ctrl_wr & pwdata[POS_CTRL_ENABLE_BIT];
   assign sw_init    = ctrl_wr & pwdata[POS_CTRL_INIT_BIT];
   // ----------------------------------------------------------------
   // Initialise: power-up once, host init falling edge, or software
   // ----------------------------------------------------------------
   logic boot;
   logic init_q;
   logic init_evt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot   <= 1'b1;
         init_q <= 1'b1;
      end else begin
         boot   <= 1'b0;
         init_q <= init_n;
      end
   end
   assign init_evt  = boot | (init_q & ~init_n) | sw_init;
   assign tof_reset = init_evt; // see R16
   // ----------------------------------------------------------------
   // Switch capture
   // ----------------------------------------------------------------
   logic       cf_spacing;
   logic       cf_form;
   logic [1:0] cf_size;
   logic [2:0] cf_charset;
   logic       cf_slct;
   logic [1:0] next_size;
   assign next_size = size_select_a ? POS_SIZE_EMPH :
                      (size_select_b ? POS_SIZE_CONDENSED : POS_SIZE_NORMAL); // see R12
   // Switches only move with power off, so one sample per init is enough
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cf_spacing <= 1'b0;
         cf_form    <= 1'b0;
         cf_size    <= POS_SIZE_NORMAL;
         cf_charset <= 3'h0;
         cf_slct    <= 1'b0;
      end else if (init_evt) begin // see R19
         cf_spacing <= spacing_switch;                  // see R10
         cf_form    <= form_length_switch;              // see R11
         cf_size    <= next_size;
         cf_charset <= {charset_switch, charset_bank2}; // see R14
         cf_slct    <= select_force_switch;
      end
   end
   assign spacing_eighth  = cf_spacing;
   assign form_twelve     = cf_form;
   assign char_size       = cf_size;
   assign charset_sel     = cf_charset;
   assign select_in_force = cf_slct; // see R15
   logic [7:0] base_cols;
   assign base_cols   = (cf_size == POS_SIZE_CONDENSED) ? POS_COLS_CONDENSED : POS_COLS_NORMAL;
   assign max_columns = enlarged ? {1'b0, base_cols[7:1]} : base_cols; // see R13
   // ----------------------------------------------------------------
   // Sensor enable
   // ----------------------------------------------------------------
   logic sense_en;
   logic ign_any;
   logic ena_any;
   assign ign_any = sensor_ignore_command | sw_ignore;
   assign ena_any = sensor_enable_command | sw_enable;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sense_en <= 1'b1;
      end else if (init_evt) begin
         sense_en <= ~sensor_disable_switch; // see R5
      end else if (ena_any) begin
         sense_en <= 1'b1;                   // see R7
      end else if (ign_any) begin
         sense_en <= 1'b0;                   // see R6
      end
   end
   // ----------------------------------------------------------------
   // Line state
   // ----------------------------------------------------------------
   pos_state_e state;
   pos_state_e next_state;
   logic       sensed_out;
   assign sensed_out = sense_en & paper_end;
   always_comb begin
      next_state = state;
      case (state)
         POS_ONLINE: begin
            if (sensed_out) begin
               next_state = POS_PAPEROUT;                      // see R2
            end else if (online_rise && !printing) begin
               next_state = POS_OFFLINE;                       // see R17
            end
         end
         POS_OFFLINE: begin
            if (sensed_out) begin
               next_state = POS_PAPEROUT;
            end else if (online_rise && !printing) begin
               next_state = POS_ONLINE;                        // see R17
            end
         end
         POS_PAPEROUT: begin
            if (!sense_en) begin
               next_state = POS_OFFLINE;                       // see R20
            end else if (online_rise && !paper_end && !printing) begin
               next_state = POS_ONLINE;                        // see R3
            end
         end
         default: begin
            next_state = POS_OFFLINE;
         end
      endcase
      if (init_evt) begin
         next_state = POS_ONLINE; // see R4
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= POS_ONLINE;
      end else begin
         state <= next_state;
      end
   end
   logic pout;
   assign pout = (state == POS_PAPEROUT);
   // ----------------------------------------------------------------
   // Host status lines, registered
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         error_n     <= 1'b1;
         paper_empty <= 1'b0;
         busy        <= 1'b1;
         ack_n       <= 1'b1;
      end else begin
         error_n     <= ~(pout | (state == POS_OFFLINE)); // see R1
         paper_empty <= pout;                            // see R1
         busy        <= (state != POS_ONLINE) | printing; // see R1
         ack_n       <= ~(ack_request & (state == POS_ONLINE)); // see R1
      end
   end
   assign print_enable   = (state == POS_ONLINE);          // see R1
   assign feed_pulse     = lf_level & (state != POS_ONLINE) & ~printing; // see R2
   assign paper_out_lamp = paper_end;                      // see R18
   assign online_lamp    = (state == POS_ONLINE);
   // ----------------------------------------------------------------
   // Self-test
   // ----------------------------------------------------------------
   logic boot_q;
   logic st_flag;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_q  <= 1'b0;
         st_flag <= 1'b0;
      end else begin
         boot_q  <= boot;
         if (boot_q && line_feed_key && !(sense_en && paper_end)) begin
            st_flag <= 1'b1; // see R8
         end
      end
   end
   // Key is sampled one cycle after power-up to let the switch capture settle
   assign selftest_start = boot_q & line_feed_key & ~(sense_en & paper_end); // see R9
   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   logic [31:0] status_word;
   logic [31:0] config_word;
   assign status_word = {27'h0, tof_reset, st_flag, sense_en, online_lamp, pout};
   assign config_word = {15'h0, cf_slct, max_columns, 1'b0, cf_charset,
                         cf_size, cf_form, cf_spacing};
   assign prdata = sel_status ? status_word :
                   (sel_config ? config_word : POS_RESET_WORD);
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_pout_lines: assert property (@(posedge pclk) disable iff (!presetn)
      pout |=> (paper_empty && !error_n && busy && ack_n)) // see R1
      else $error("paper-out lines wrong");
   a_pout_entry: assert property (@(posedge pclk) disable iff (!presetn)
      (sensed_out && !init_evt) |=> pout)                  // see R2
      else $error("paper out not entered");
   a_online_rel: assert property (@(posedge pclk) disable iff (!presetn)
      (pout && online_rise && !paper_end && sense_en && !init_evt && !printing)
      |=> online_lamp)                                     // see R3
      else $error("release by key failed");
   a_init_clear: assert property (@(posedge pclk) disable iff (!presetn)
      init_evt |=> (online_lamp && !pout))                 // see R4
      else $error("init did not clear");
   a_ign_cmd: assert property (@(posedge pclk) disable iff (!presetn)
      (ign_any && !ena_any && !init_evt) |=> !sense_en)    // see R6
      else $error("ignore command failed");
   a_ena_cmd: assert property (@(posedge pclk) disable iff (!presetn)
      (ena_any && !init_evt) |=> sense_en)                 // see R7
      else $error("enable command failed");
   a_no_test: assert property (@(posedge pclk) disable iff (!presetn)
      (sense_en && paper_end) |-> !selftest_start)         // see R9
      else $error("self-test while out of paper");
   a_key_busy: assert property (@(posedge pclk) disable iff (!presetn)
      (online_lamp && printing && !sensed_out && !init_evt) |=> online_lamp) // see R17
      else $error("online key acted while printing");
   a_cols_half: assert property (@(posedge pclk) disable iff (!presetn)
      (enlarged && cf_size == POS_SIZE_CONDENSED) |-> max_columns == 8'h42) // see R13
      else $error("column halving wrong");
   a_cfg_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !init_evt |=> $stable(cf_size) && $stable(cf_spacing)) // see R19
      else $error("switches resampled");
   c_pout: cover property (@(posedge pclk) disable iff (!presetn) $rose(pout));
   c_rel: cover property (@(posedge pclk) disable iff (!presetn) pout ##1 online_lamp);
   c_test: cover property (@(posedge pclk) disable iff (!presetn) selftest_start);
   c_ign: cover property (@(posedge pclk) disable iff (!presetn) $fell(sense_en));
endmodule
`default_nettype wire

// ==== shared/pos_pkg.sv ====
// Constants and types for the paper-out and switch configuration block
package pos_pkg;
   // -------------------------------------------------------------
   // Register map (APB byte addresses)
   // -------------------------------------------------------------
   localparam logic [11:0] POS_CTRL_OFF   = 12'h000;
   localparam logic [11:0] POS_STATUS_OFF = 12'h004;
   localparam logic [11:0] POS_CONFIG_OFF = 12'h008;
   // -------------------------------------------------------------
   // Control register fields (write 1 pulses)
   // -------------------------------------------------------------
   localparam int POS_CTRL_IGNORE_BIT = 0;
   localparam int POS_CTRL_ENABLE_BIT = 1;
   localparam int POS_CTRL_INIT_BIT   = 2;
   // -------------------------------------------------------------
   // Status register fields
   // -------------------------------------------------------------
   localparam int POS_ST_PAPER_OUT_BIT = 0;
   localparam int POS_ST_ONLINE_BIT    = 1;
   localparam int POS_ST_SENSE_EN_BIT  = 2;
   localparam int POS_ST_SELFTEST_BIT  = 3;
   localparam int POS_ST_TOF_BIT       = 4;
   // -------------------------------------------------------------
   // Config register fields
   // -------------------------------------------------------------
   localparam int POS_CF_SPACING_BIT = 0;
   localparam int POS_CF_FORM_BIT    = 1;
   localparam int POS_CF_SIZE_LSB    = 2;
   localparam int POS_CF_CHARSET_LSB = 4;
   localparam int POS_CF_COLS_LSB    = 8;
   localparam int POS_CF_SLCT_BIT    = 16;
   // -------------------------------------------------------------
   // Values
   // -------------------------------------------------------------
   localparam logic [7:0] POS_COLS_NORMAL    = 8'h50;
   localparam logic [7:0] POS_COLS_CONDENSED = 8'h84;
   localparam logic [1:0] POS_SIZE_NORMAL    = 2'h0;
   localparam logic [1:0] POS_SIZE_CONDENSED = 2'h1;
   localparam logic [1:0] POS_SIZE_EMPH      = 2'h2;
   localparam logic [31:0] POS_RESET_WORD    = 32'h0000_0000;
   typedef enum logic [2:0] {
      POS_ONLINE   = 3'b001,
      POS_OFFLINE  = 3'b010,
      POS_PAPEROUT = 3'b100
   } pos_state_e;
endpackage

// ==== design/pos_sync_edge.sv ====
// Three-stage input filter (level from the second stage) with rising edge pulse for a panel key
`timescale 1ns/1ps
`default_nettype none
module pos_sync_edge (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Key
   input  wire logic key_in,
   output logic      level,
   output logic      rise
);
   logic stage1;
   logic stage2;
   logic stage3;
   // Keys are mechanical; settle them before edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
      end else begin
         stage1 <= key_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end
   assign level = stage2;
   assign rise  = stage2 & ~stage3;
endmodule
`default_nettype wire

// ==== sim/pos_host_model.sv ====
// Host side model: init line, sensor commands and the wired-OR select line
`timescale 1ns/1ps
`default_nettype none
module pos_host_model (
   // Clock
   input  wire logic pclk,
   // Device status lines
   input  wire logic ack_n,
   input  wire logic select_in_force,
   // Host drive
   output logic      init_n,
   output logic      sensor_ignore_command,
   output logic      sensor_enable_command,
   output logic      slct_in_line
);
   logic slct_host;
   int   ack_cnt;
   initial begin
      init_n = 1'b1;
      sensor_ignore_command = 1'b0;
      sensor_enable_command = 1'b0;
      slct_host = 1'b0;
      ack_cnt = 0;
   end
   // Host leaves its own select source idle so only the device can assert it
   assign slct_in_line = slct_host | select_in_force;
   // Every acknowledge pulse is counted; the bench expects none in paper out
   always @(negedge ack_n) ack_cnt++;
   // Init held low for a few cycles; the device acts on the falling edge
   task pulse_init;
      @(posedge pclk) init_n <= 1'b0;
      repeat (4) @(posedge pclk);
      init_n <= 1'b1;
      repeat (4) @(posedge pclk);
   endtask
   // One-cycle command pulse, as from the code decoder
   task send_cmd(input logic en);
      @(posedge pclk);
      if (en) sensor_enable_command <= 1'b1;
      else sensor_ignore_command <= 1'b1;
      @(posedge pclk);
      sensor_enable_command <= 1'b0;
      sensor_ignore_command <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
endmodule
`default_nettype wire

// ==== sim/tb_paper_out_and_switch_config.sv ====
// Self-checking bench for the paper-out and switch configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_paper_out_and_switch_config;
   import pos_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed, e_cfg;
   logic paper_end, online_key, line_feed_key, printing, enlarged, ack_request;
   logic spacing_switch, form_length_switch, size_select_a, size_select_b;
   logic sensor_disable_switch, charset_switch, select_force_switch, err;
   logic [1:0] charset_bank2, char_size, e_sz;
   logic [7:0] max_columns, e_cols;
   logic [2:0] charset_sel;
   logic init_n, s_ign, s_en, error_n, paper_empty, busy, ack_n, select_in_force;
   logic print_enable, feed_pulse, tof_reset, selftest_start, paper_out_lamp;
   logic online_lamp, spacing_eighth, form_twelve, slct_in_line;
   int n_fail, total_checks, n_tof, n_st, t0, s0, a0;
   pos_paper_ctrl i_pos_paper_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .paper_end(paper_end),
      .online_key(online_key), .line_feed_key(line_feed_key), .printing(printing),
      .enlarged(enlarged), .spacing_switch(spacing_switch),
      .form_length_switch(form_length_switch), .size_select_a(size_select_a),
      .size_select_b(size_select_b), .sensor_disable_switch(sensor_disable_switch),
      .charset_switch(charset_switch), .charset_bank2(charset_bank2),
      .select_force_switch(select_force_switch), .init_n(init_n),
      .sensor_ignore_command(s_ign), .sensor_enable_command(s_en),
      .ack_request(ack_request), .error_n(error_n), .paper_empty(paper_empty),
      .busy(busy), .ack_n(ack_n), .select_in_force(select_in_force),
      .print_enable(print_enable), .feed_pulse(feed_pulse), .tof_reset(tof_reset),
      .selftest_start(selftest_start), .paper_out_lamp(paper_out_lamp),
      .online_lamp(online_lamp), .spacing_eighth(spacing_eighth),
      .form_twelve(form_twelve), .char_size(char_size), .max_columns(max_columns),
      .charset_sel(charset_sel));
   pos_host_model i_pos_host_model (.pclk(pclk), .ack_n(ack_n),
      .select_in_force(select_in_force), .init_n(init_n), .sensor_ignore_command(s_ign),
      .sensor_enable_command(s_en), .slct_in_line(slct_in_line));
   // ---------------------------------------------------------------
   // Clock, pulse counters, watchdog
   // ---------------------------------------------------------------
   always #4 pclk = ~pclk;
   always @(posedge pclk) begin
      if (tof_reset === 1'b1) n_tof++;
      if (selftest_start === 1'b1) n_st++;
   end
   initial begin
      repeat (60000) @(posedge pclk);
      n_fail++;
      print_verdict;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task settle(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask
   // APB transfer; ready, read data and error are taken at the completing edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      logic ok;
      ok = 1'b0;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk) penable <= 1'b1;
      for (int k = 0; k < 40 && !ok; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) begin
            ok = 1'b1;
            rd = prdata;
            err = pslverr;
         end
      end
      if (!ok) print_fail_wait;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task print_fail_wait;
      n_fail++;
      print_verdict;
   endtask
   task press(input logic lf);
      @(posedge pclk);
      if (lf) line_feed_key <= 1'b1;
      else online_key <= 1'b1;
      settle(8);
   endtask
   task release_keys;
      @(posedge pclk) {line_feed_key, online_key} <= 2'b00;
      settle(4);
   endtask
   // Power cycle with switch bank taken from sw
   task boot(input logic [7:0] sw, input logic lf, input logic pe);
      @(posedge pclk) presetn <= 1'b0;
      {spacing_switch, form_length_switch, size_select_a, size_select_b} <= sw[3:0];
      {charset_switch, charset_bank2, select_force_switch} <= sw[7:4];
      sensor_disable_switch <= sw[5] & ~pe;
      enlarged <= sw[6];
      {paper_end, line_feed_key} <= {pe, lf};
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      // Tof_reset also stands during reset, so count only after the release edge
      @(negedge pclk) {t0, s0} = {n_tof, n_st};
      settle(8);
      release_keys;
      `CHK(n_tof - t0, 1)
      `CHK(n_st - s0, int'(lf & ~pe))
   endtask
   task calc;
      e_sz = size_select_a ? 2'h2 : size_select_b ? 2'h1 : 2'h0;
      e_cols = (e_sz == 2'h1 ? 8'h84 : 8'h50) >> enlarged;
      e_cfg = {15'h0, select_force_switch, 9'h0, charset_switch, charset_bank2, e_sz,
               form_length_switch, spacing_switch};
   endtask
   task check_cfg;
      `CHK(spacing_eighth, e_cfg[0])
      `CHK(form_twelve, e_cfg[1])
      `CHK(char_size, e_sz)
      `CHK(max_columns, e_cols)
      `CHK(charset_sel, e_cfg[6:4])
      `CHK(slct_in_line, e_cfg[16])
      apb(1'b0, POS_CONFIG_OFF, 32'h0);
      `CHK(rd & 32'h0001_007F, e_cfg)
   endtask
   task check_po(input logic po);
      settle(4);
      `CHK({paper_empty, error_n, online_lamp, print_enable}, {po, ~po, ~po, ~po})
      if (po) `CHK(busy, 1'b1)
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {pclk, psel, penable, pwrite, paddr, pwdata} = '0;
      {paper_end, online_key, line_feed_key, printing, enlarged, ack_request} = '0;
      {spacing_switch, form_length_switch, size_select_a, size_select_b} = '0;
      {sensor_disable_switch, charset_switch, charset_bank2, select_force_switch} = '0;
      {n_fail, total_checks, n_tof, n_st} = '0;
      presetn = 1'b0;
      seed = 32'hCEB1BFAA;
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(lfsr(seed));
         boot(seed[7:0], i == 1 || i == 3, i == 3);
         calc;
         check_cfg;
         @(posedge pclk);
         {spacing_switch, form_length_switch, size_select_a, charset_switch} <= ~seed[3:0];
         select_force_switch <= ~seed[7];
         settle(4);
         check_cfg;
      end
      boot(8'h00, 1'b0, 1'b0);
      @(posedge pclk) paper_end <= 1'b1;
      check_po(1'b1);
      `CHK(paper_out_lamp, 1'b1)
      a0 = i_pos_host_model.ack_cnt;
      @(posedge pclk) ack_request <= 1'b1;
      repeat (3) @(posedge pclk);
      ack_request <= 1'b0;
      settle(4);
      `CHK(i_pos_host_model.ack_cnt, a0)
      apb(1'b0, POS_STATUS_OFF, 32'h0);
      `CHK(rd[2:0], 3'b101)
      press(1'b1);
      `CHK(feed_pulse, 1'b1)
      release_keys;
      @(posedge pclk) {paper_end, printing} <= 2'b01;
      check_po(1'b1);
      `CHK(paper_out_lamp, 1'b0)
      press(1'b0);
      release_keys;
      check_po(1'b1);
      @(posedge pclk) printing <= 1'b0;
      press(1'b0);
      release_keys;
      check_po(1'b0);
      a0 = i_pos_host_model.ack_cnt;
      @(posedge pclk) ack_request <= 1'b1;
      @(posedge pclk) ack_request <= 1'b0;
      settle(2);
      `CHK(i_pos_host_model.ack_cnt - a0, 1)
      i_pos_host_model.send_cmd(1'b0);
      @(posedge pclk) paper_end <= 1'b1;
      check_po(1'b0);
      apb(1'b1, POS_CTRL_OFF, 32'h2);
      check_po(1'b1);
      @(posedge pclk) {paper_end, size_select_b, form_length_switch} <= 3'b011;
      t0 = n_tof;
      i_pos_host_model.pulse_init;
      check_po(1'b0);
      `CHK(n_tof - t0, 1)
      calc;
      check_cfg;
      t0 = n_tof;
      apb(1'b1, POS_CTRL_OFF, 32'h4);
      settle(4);
      `CHK(n_tof - t0, 1)
      boot(8'h20, 1'b0, 1'b0);
      @(posedge pclk) paper_end <= 1'b1;
      check_po(1'b0);
      i_pos_host_model.send_cmd(1'b1);
      check_po(1'b1);
      apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
      `CHK(err, 1'b1)
      apb(1'b0, 12'h00C, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      print_verdict;
   end
   task print_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
endmodule
`default_nettype wire
